// ### dcr_map.svh
// Register numbers, field positions, limits and reset values of the drive
// communications register map. Included by the register bank module.
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
// Slave addressing
`define DCR_ADDR_BCAST       8'h00
`define DCR_ADDR_MIN         8'h01
`define DCR_ADDR_MAX         8'h20
// Command registers
`define DCR_REG_RUN          16'h0001
`define DCR_REG_SETPT        16'h0002
`define DCR_REG_VGAIN        16'h0003
`define DCR_REG_OUTCTL       16'h0009
`define DCR_REG_UNIT         16'h0198
`define DCR_REG_MAP_TOP      16'h00ff
// Monitor registers
`define DCR_REG_STATUS       16'h0020
`define DCR_REG_FAULT1       16'h0021
`define DCR_REG_LINK         16'h0022
`define DCR_REG_SETPT_MON    16'h0023
`define DCR_REG_OUTFRQ_MON   16'h0024
`define DCR_REG_CURR_MON     16'h0027
`define DCR_REG_VOLT_MON     16'h0028
`define DCR_REG_FAULT2       16'h0029
`define DCR_REG_WARN         16'h002a
`define DCR_REG_IN_TERM      16'h002b
`define DCR_REG_STATE1       16'h002c
`define DCR_REG_OUT_TERM     16'h002d
`define DCR_REG_STATE2       16'h002e
`define DCR_REG_DCBUS        16'h0031
`define DCR_REG_TORQUE       16'h0032
`define DCR_REG_HOURS        16'h0035
`define DCR_REG_POWER        16'h0037
`define DCR_REG_LOOP_FB      16'h0038
`define DCR_REG_LOOP_IN      16'h0039
`define DCR_REG_LOOP_OUT     16'h003a
`define DCR_REG_LINK_ERR     16'h003d
// Field positions and limits
`define DCR_RUN_BITS         11
`define DCR_BCAST_BITS       4
`define DCR_FLT_RESET_BIT    3
`define DCR_VGAIN_MIN        16'h0014
`define DCR_VGAIN_MAX        16'h07d0
`define DCR_VGAIN_RST        16'h03e8
`define DCR_FUNC_COMM_OUT    8'h12
`define DCR_ERR_REGNUM       8'h02
`define DCR_ERR_DATA         8'h21
`define DCR_FUNC_ERR_BIT     8'h80
`endif

// ### dcr_pkg.sv
// Types shared by the drive communications register bank.
// Assumes a message layer that has already checked framing and CRC.
package dcr_pkg;
  // One decoded register access from the serial link
  typedef struct packed {
    logic        valid;
    logic [7:0]  slave;
    logic [7:0]  func;
    logic        write;
    logic [15:0] regnum;
    logic [15:0] wdata;
  } dcr_req_t;
  // Answer to the message layer
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic        err;
    logic [7:0]  code;
    logic [15:0] rdata;
  } dcr_rsp_t;
  // Live values from the drive core, already in link units
  typedef struct packed {
    logic        running;
    logic        reversing;
    logic        ready;
    logic        faulted;
    logic        verify_fault;
    logic [15:0] setpt_mon;
    logic [15:0] outfrq_mon;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] warn;
    logic [15:0] state1;
    logic [15:0] state2;
    logic [15:0] dcbus;
    logic [15:0] torque;
    logic [15:0] hours;
    logic [15:0] power;
    logic [15:0] loop_fb;
    logic [15:0] loop_in;
    logic [15:0] loop_out;
    logic [15:0] link_err;
  } dcr_mon_t;
  // Whole state of the register bank
  typedef struct packed {
    logic [10:0] run_cmd;
    logic [15:0] setpt;
    logic        setpt_bcast;
    logic [15:0] vgain;
    logic [2:0]  out_ctl;
    logic [15:0] unit_sel;
    logic [15:0] fault1;
    logic [15:0] fault2;
    logic        writing;
    logic        range_err;
    dcr_rsp_t    rsp;
  } dcr_state_t;
endpackage

// ### dcr_regs.sv
// Register bank of the drive serial communications port: command
// registers, frequency unit selection and read-only monitors.
// Assumes decoded, CRC-checked requests arrive one per message.
`timescale 1ns/10ps
`default_nettype none
`include "dcr_map.svh"

// Summary of operation
// R1: Answer own slave address 01 to 32
// R2: Single-slave setpoint uses selected frequency unit
// R3: Unit select register 0198 scales frequency
// R4: Voltage gain 20 to 2000, 1000 unity
// R5: Command reads return last written value
// R6: Run word bits 0-3 run/reverse/fault/reset
// R7: Run word bits 4-10 drive inputs 1-7
// R8: Run word bits 11-15 read zero
// R9: Command bits ORed with terminal inputs
// R10: Output word bits 0-2 drive outputs
// R11: Output follows bit only with code 18
// R12: Broadcast address 00 writes run, setpoint only
// R13: Broadcast setpoint full scale 30000 counts
// R14: Broadcast run word uses bits 0-3 only
// R15: Current 10/A, voltages 1/V monitors
// R16: Power 100/kW signed, hours 1/h
// R17: Loop monitors 10 per percent
// R18: Status word bits from drive state
// R19: Fault sets its fault status bit
// R20: Link status writing, range, verify bits
// R21: Large-variant registers included by option
// R22: Error answer sets function code MSB
// R23: Unused registers read zero, ignore writes
module dcr_regs
  import dcr_pkg::*;
#(
  parameter bit LARGE_BUILD = 1'b0
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // Own slave address strap
  input  wire logic [7:0]  SLAVE_ADDR,
  // Request from message layer
  input  wire dcr_req_t    REQ,
  // Answer to message layer
  output dcr_rsp_t         RSP,
  // Control terminals and drive core state
  input  wire logic [10:0] TERM_CMD,
  input  wire dcr_mon_t    MON,
  input  wire logic [15:0] FAULT1_EV,
  input  wire logic [15:0] FAULT2_EV,
  // Output terminal function selects and core output values
  input  wire logic [7:0]  OUT_FUNC_SEL [3],
  input  wire logic [2:0]  CORE_OUT,
  // Commands to the drive core
  output logic [10:0]      RUN_CMD_EFF,
  output logic [15:0]      SETPOINT,
  output logic             SETPOINT_BCAST,
  output logic [15:0]      VOLTAGE_GAIN,
  output logic [15:0]      COMM_UNIT_SEL,
  // Output terminals
  output logic [2:0]       OUT_TERM
);

  dcr_state_t st_r;
  dcr_state_t st_nxt;

  logic        own_ok;
  logic        hit;
  logic        bcast;
  logic        known;
  logic        flt_reset;
  logic [15:0] rd_val;
  logic [15:0] status_word;
  logic [15:0] link_word;
  logic [15:0] wd;

  // Address and request qualification
  assign own_ok = (SLAVE_ADDR >= `DCR_ADDR_MIN) &&
                  (SLAVE_ADDR <= `DCR_ADDR_MAX);                // R1
  assign hit    = REQ.valid && own_ok && (REQ.slave == SLAVE_ADDR); // R1
  assign bcast  = REQ.valid && REQ.write &&
                  (REQ.slave == `DCR_ADDR_BCAST);               // R12
  assign known  = (REQ.regnum <= `DCR_REG_MAP_TOP) ||
                  (REQ.regnum == `DCR_REG_UNIT);
  assign wd     = REQ.wdata;

  // Fault reset seen from either command path
  assign flt_reset = RUN_CMD_EFF[`DCR_FLT_RESET_BIT];

  // Status word from drive state and terminals
  always_comb begin
    status_word    = 16'h0000;                                  // R18
    status_word[0] = MON.running;                               // R18
    status_word[1] = MON.reversing;                             // R18
    status_word[2] = MON.ready;                                 // R18
    status_word[3] = MON.faulted;                               // R18
    status_word[4] = st_r.range_err | MON.verify_fault;         // R18
    status_word[7:5] = OUT_TERM;                                // R18
  end

  // Data link status word
  always_comb begin
    link_word    = 16'h0000;
    link_word[0] = st_r.writing;                                // R20
    link_word[3] = st_r.range_err;                              // R20
    link_word[4] = MON.verify_fault;                            // R20
  end

  // Read multiplexer; unused numbers read zero
  always_comb begin
    rd_val = 16'h0000;                                          // R23
    case (REQ.regnum)
      `DCR_REG_RUN: begin
        rd_val = {5'h00, st_r.run_cmd};                         // R5 R8
      end
      `DCR_REG_SETPT: begin
        rd_val = st_r.setpt;                                    // R5
      end
      `DCR_REG_VGAIN: begin
        rd_val = st_r.vgain;                                    // R5
      end
      `DCR_REG_OUTCTL: begin
        rd_val = {13'h0000, st_r.out_ctl};                      // R5
      end
      `DCR_REG_UNIT: begin
        rd_val = st_r.unit_sel;                                 // R3
      end
      `DCR_REG_STATUS: begin
        rd_val = status_word;
      end
      `DCR_REG_FAULT1: begin
        rd_val = st_r.fault1;                                   // R19
      end
      `DCR_REG_LINK: begin
        rd_val = link_word;
      end
      `DCR_REG_SETPT_MON: begin
        rd_val = MON.setpt_mon;                                 // R3
      end
      `DCR_REG_OUTFRQ_MON: begin
        rd_val = MON.outfrq_mon;                                // R3
      end
      `DCR_REG_CURR_MON: begin
        rd_val = MON.current;                                   // R15
      end
      `DCR_REG_VOLT_MON: begin
        rd_val = MON.voltage;                                   // R15
      end
      `DCR_REG_FAULT2: begin
        rd_val = LARGE_BUILD ? st_r.fault2 : 16'h0000;          // R21
      end
      `DCR_REG_WARN: begin
        rd_val = LARGE_BUILD ? MON.warn : 16'h0000;             // R21
      end
      `DCR_REG_IN_TERM: begin
        rd_val = {9'h000, TERM_CMD[10:4]};
      end
      `DCR_REG_STATE1: begin
        rd_val = MON.state1;
      end
      `DCR_REG_OUT_TERM: begin
        rd_val = {13'h0000, OUT_TERM};
      end
      `DCR_REG_STATE2: begin
        rd_val = LARGE_BUILD ? MON.state2 : 16'h0000;           // R21
      end
      `DCR_REG_DCBUS: begin
        rd_val = MON.dcbus;                                     // R15
      end
      `DCR_REG_TORQUE: begin
        rd_val = MON.torque;
      end
      `DCR_REG_HOURS: begin
        rd_val = LARGE_BUILD ? MON.hours : 16'h0000;            // R16 R21
      end
      `DCR_REG_POWER: begin
        rd_val = MON.power;                                     // R16
      end
      `DCR_REG_LOOP_FB: begin
        rd_val = MON.loop_fb;                                   // R17
      end
      `DCR_REG_LOOP_IN: begin
        rd_val = MON.loop_in;                                   // R17
      end
      `DCR_REG_LOOP_OUT: begin
        rd_val = MON.loop_out;                                  // R17
      end
      `DCR_REG_LINK_ERR: begin
        rd_val = MON.link_err;
      end
      default: begin
        rd_val = 16'h0000;                                      // R23
      end
    endcase
  end

  // Next-state logic for the whole bank
  always_comb begin
    st_nxt           = st_r;
    st_nxt.writing   = 1'b0;
    st_nxt.rsp       = '0;
    // Sticky fault flags; a new fault wins over reset
    st_nxt.fault1    = (flt_reset ? 16'h0000 : st_r.fault1) | FAULT1_EV; // R19
    st_nxt.fault2    = (flt_reset ? 16'h0000 : st_r.fault2) |
                       (LARGE_BUILD ? FAULT2_EV : 16'h0000);    // R19 R21
    // Single-slave access
    if (hit) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.func  = REQ.func;
      if (!known) begin
        st_nxt.rsp.err  = 1'b1;
        st_nxt.rsp.func = REQ.func | `DCR_FUNC_ERR_BIT;         // R22
        st_nxt.rsp.code = `DCR_ERR_REGNUM;                      // R22
      end else if (!REQ.write) begin
        st_nxt.rsp.rdata = rd_val;                              // R1
      end else begin
        st_nxt.writing = 1'b1;                                  // R20
        case (REQ.regnum)
          `DCR_REG_RUN: begin
            st_nxt.run_cmd   = wd[`DCR_RUN_BITS-1:0];           // R6 R7 R8
            st_nxt.range_err = 1'b0;
          end
          `DCR_REG_SETPT: begin
            st_nxt.setpt       = wd;                            // R2
            st_nxt.setpt_bcast = 1'b0;                          // R2
            st_nxt.range_err   = 1'b0;
          end
          `DCR_REG_VGAIN: begin
            if (wd >= `DCR_VGAIN_MIN && wd <= `DCR_VGAIN_MAX) begin
              st_nxt.vgain     = wd;                            // R4
              st_nxt.range_err = 1'b0;
            end else begin
              st_nxt.range_err = 1'b1;                          // R4 R20
              st_nxt.rsp.err   = 1'b1;
              st_nxt.rsp.func  = REQ.func | `DCR_FUNC_ERR_BIT;  // R22
              st_nxt.rsp.code  = `DCR_ERR_DATA;
            end
          end
          `DCR_REG_OUTCTL: begin
            st_nxt.out_ctl   = wd[2:0];                         // R10
            st_nxt.range_err = 1'b0;
          end
          `DCR_REG_UNIT: begin
            st_nxt.unit_sel  = wd;                              // R3
            st_nxt.range_err = 1'b0;
          end
          default: begin
            st_nxt.range_err = st_r.range_err;                  // R23
          end
        endcase
      end
    end else if (bcast) begin
      // Broadcast: no answer, two registers only
      case (REQ.regnum)
        `DCR_REG_RUN: begin
          st_nxt.writing = 1'b1;
          st_nxt.run_cmd[`DCR_BCAST_BITS-1:0] =
            wd[`DCR_BCAST_BITS-1:0];                            // R12 R14
        end
        `DCR_REG_SETPT: begin
          st_nxt.writing     = 1'b1;
          st_nxt.setpt       = wd;                              // R12 R13
          st_nxt.setpt_bcast = 1'b1;                            // R13
        end
        default: begin
          st_nxt.writing = 1'b0;                                // R12
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r          <= '0;
      st_r.vgain    <= `DCR_VGAIN_RST;
    end else begin
      st_r          <= st_nxt;
    end
  end

  // Commands to the core, terminals ORed in
  assign RUN_CMD_EFF    = st_r.run_cmd | TERM_CMD;              // R9
  assign SETPOINT       = st_r.setpt;
  assign SETPOINT_BCAST = st_r.setpt_bcast;                     // R13
  assign VOLTAGE_GAIN   = st_r.vgain;                           // R4
  assign COMM_UNIT_SEL  = st_r.unit_sel;                        // R3
  assign RSP            = st_r.rsp;

  // Output terminals: link bit only when selected for comms
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      OUT_TERM[i] = (OUT_FUNC_SEL[i] == `DCR_FUNC_COMM_OUT) ?
                    st_r.out_ctl[i] : CORE_OUT[i];              // R10 R11
    end
  end

endmodule
`default_nettype wire

// ### dcr_monitor.sv
// Checker for the drive register bank, seen from its ports only.
// Assumes it is bound to every instance of dcr_regs.
`timescale 1ns/10ps
`default_nettype none
module dcr_monitor
  import dcr_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  // Link side
  input wire logic [7:0]  SLAVE_ADDR,
  input wire dcr_req_t    REQ,
  input wire dcr_rsp_t    RSP,
  // Drive side
  input wire logic [10:0] TERM_CMD,
  input wire logic [7:0]  OUT_FUNC_SEL [3],
  input wire logic [2:0]  CORE_OUT,
  input wire logic [10:0] RUN_CMD_EFF,
  input wire logic [15:0] SETPOINT,
  input wire logic        SETPOINT_BCAST,
  input wire logic [15:0] VOLTAGE_GAIN,
  input wire logic [15:0] COMM_UNIT_SEL,
  input wire logic [2:0]  OUT_TERM
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Request decode
  logic        own_w;
  logic        bc_w;
  logic [15:0] wd;
  logic [3:0]  wd4;
  assign own_w = REQ.valid && REQ.write && REQ.slave == SLAVE_ADDR;
  assign bc_w = REQ.valid && REQ.write && REQ.slave == 8'h00;
  assign wd = REQ.wdata;
  assign wd4 = REQ.wdata[3:0];
  own_answer_a: assert property (
    REQ.valid && REQ.slave == SLAVE_ADDR && SLAVE_ADDR inside {[8'h01:8'h20]} |=> RSP.valid)
    else $error("no answer");
  bcast_quiet_a: assert property (
    REQ.valid && REQ.slave == 8'h00 |=> !RSP.valid) else $error("broadcast answered");
  err_func_a: assert property (
    RSP.valid && RSP.err |-> RSP.func[7] && RSP.code inside {8'h02, 8'h21})
    else $error("bad error answer");
  run_write_a: assert property (
    own_w && REQ.regnum == 16'h0001 |=> {5'h00, RUN_CMD_EFF} == ($past(wd) | {5'h00, TERM_CMD}))
    else $error("run word wrong");
  term_or_a: assert property (
    (RUN_CMD_EFF & TERM_CMD) == TERM_CMD) else $error("terminal lost");
  bcast_run_a: assert property (
    bc_w && REQ.regnum == 16'h0001 |=> RUN_CMD_EFF[3:0] == ($past(wd4) | TERM_CMD[3:0]))
    else $error("broadcast run wrong");
  bcast_keep_a: assert property (
    bc_w && REQ.regnum == 16'h0001 ##1 $stable(TERM_CMD) |->
      RUN_CMD_EFF[10:4] == $past(RUN_CMD_EFF[10:4])) else $error("broadcast touched inputs");
  setpt_load_a: assert property (
    (own_w || bc_w) && REQ.regnum == 16'h0002 |=>
      SETPOINT == $past(wd) && SETPOINT_BCAST == $past(bc_w)) else $error("setpoint wrong");
  unit_load_a: assert property (
    own_w && REQ.regnum == 16'h0198 |=> COMM_UNIT_SEL == $past(wd)) else $error("unit wrong");
  gain_range_a: assert property (
    VOLTAGE_GAIN inside {[16'h0014:16'h07d0]}) else $error("gain out of range");
  out_core_a: assert property (
    OUT_FUNC_SEL[1] != 8'h12 |-> OUT_TERM[1] == CORE_OUT[1]) else $error("output not core");
endmodule
bind dcr_regs dcr_monitor u_mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .SLAVE_ADDR(SLAVE_ADDR), .REQ(REQ), .RSP(RSP), .TERM_CMD(TERM_CMD),
  .OUT_FUNC_SEL(OUT_FUNC_SEL), .CORE_OUT(CORE_OUT), .RUN_CMD_EFF(RUN_CMD_EFF),
  .SETPOINT(SETPOINT), .SETPOINT_BCAST(SETPOINT_BCAST), .VOLTAGE_GAIN(VOLTAGE_GAIN),
  .COMM_UNIT_SEL(COMM_UNIT_SEL), .OUT_TERM(OUT_TERM));
`default_nettype wire

// ### dcr_master.sv
// Serial master model: one decoded register access at a time.
// Assumes the bank answers on the same edge at which it samples a request.
`timescale 1ns/10ps
`default_nettype none
module dcr_master
  import dcr_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Request out, answer in
  output var dcr_req_t  req,
  input  wire dcr_rsp_t rsp
);
  dcr_rsp_t last;
  initial req = '0;
  // Hold the request over one edge, then take the answer
  task automatic acc(input logic w, input logic [7:0] s, input logic [15:0] r,
                     input logic [15:0] d);
    logic [15:0] dd;
    dd = (r == 16'h0001) ? (d & 16'h07ff) : d;
    @(posedge clk);
    req <= '{1'b1, s, w ? 8'h10 : 8'h03, w, r, dd};
    @(posedge clk);
    req.valid <= 1'b0;
    req.wdata <= ~dd; // Released data does not keep its value
    #1 last = rsp;
  endtask
  // Write, then read on the very next edge; the read's answer is kept
  task automatic acc_pair(input logic [7:0] s, input logic [15:0] wr_r,
                          input logic [15:0] wr_d, input logic [15:0] rd_r);
    logic [15:0] dd;
    dd = (wr_r == 16'h0001) ? (wr_d & 16'h07ff) : wr_d;
    @(posedge clk);
    req <= '{1'b1, s, 8'h10, 1'b1, wr_r, dd};
    @(posedge clk);
    req <= '{1'b1, s, 8'h03, 1'b0, rd_r, ~dd};
    @(posedge clk);
    req.valid <= 1'b0;
    #1 last = rsp;
  endtask
endmodule
`default_nettype wire

// ### tb_drive_comms_register_map.sv
// Self-checking bench for the drive register bank.
// Assumes the master model and bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_drive_comms_register_map
  import dcr_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [10:0] term;
  logic [10:0] run_eff;
  logic [15:0] f1;
  logic [15:0] setpt;
  logic [15:0] vgain;
  logic [15:0] unit;
  logic [7:0]  sel [3];
  logic [7:0]  own;
  logic [2:0]  core;
  logic [2:0]  out_term;
  logic        sp_bc;
  dcr_req_t    req;
  dcr_rsp_t    rsp;
  dcr_mon_t    mon;
  int          bad_count = 0;
  int          n_compared = 0;
  dcr_regs u_dut (.CLK_SYS(clk), .RESET_N(rst_n), .SLAVE_ADDR(own), .REQ(req), .RSP(rsp),
    .TERM_CMD(term), .MON(mon), .FAULT1_EV(f1), .FAULT2_EV(16'h0000), .OUT_FUNC_SEL(sel),
    .CORE_OUT(core), .RUN_CMD_EFF(run_eff), .SETPOINT(setpt), .SETPOINT_BCAST(sp_bc),
    .VOLTAGE_GAIN(vgain), .COMM_UNIT_SEL(unit), .OUT_TERM(out_term));
  dcr_master u_mst (.clk(clk), .req(req), .rsp(rsp));
  // Own-address write and checked read
  task automatic wr(input logic [15:0] r, input logic [15:0] d);
    u_mst.acc(1'b1, 8'h20, r, d);
  endtask
  task automatic rd(input logic [15:0] r, input logic [15:0] e);
    u_mst.acc(1'b0, 8'h20, r, 16'h0000);
    `CHK({u_mst.last.valid, u_mst.last.err, u_mst.last.rdata}, {2'b10, e})
  endtask
  // Run word read-back and terminal OR
  task automatic t_cmd;
    rd(16'h0001, 16'h0000);
    wr(16'h0001, 16'h07ff);
    `CHK(run_eff, 11'h7ff)
    rd(16'h0001, 16'h07ff);
    @(posedge clk) term <= 11'h001;
    wr(16'h0001, 16'h0002);
    `CHK(run_eff, 11'h003)
    rd(16'h0001, 16'h0002);
    @(posedge clk) term <= 11'h000;
    wr(16'h0001, 16'h0000);
  endtask
  // Gain limits, refusal and range flag
  task automatic t_gain;
    logic [15:0] v [4] = '{16'h07d1, 16'h0013, 16'h0014, 16'h07d0};
    rd(16'h0003, 16'h03e8);
    for (int i = 0; i < 4; i++) begin
      wr(16'h0003, v[i]);
      `CHK({u_mst.last.err, u_mst.last.code, u_mst.last.func}, i < 2 ? 17'h12190 : 17'h00010)
      `CHK(vgain, i < 2 ? 16'h03e8 : v[i])
      rd(16'h0022, i < 2 ? 16'h0008 : 16'h0000);
    end
    u_mst.acc_pair(8'h20, 16'h0003, 16'h07d0, 16'h0022);
    `CHK({u_mst.last.valid, u_mst.last.rdata}, {1'b1, 16'h0001})
  endtask
  // Unused and unmapped numbers
  task automatic t_map;
    wr(16'h0005, 16'h1234);
    `CHK(u_mst.last.err, 1'b0)
    rd(16'h0005, 16'h0000);
    rd(16'h0029, 16'h0000);
    u_mst.acc(1'b0, 8'h20, 16'h0200, 16'h0000);
    `CHK({u_mst.last.func, u_mst.last.code}, 16'h8302)
  endtask
  // Broadcast and foreign address
  task automatic t_bcast;
    wr(16'h0001, 16'h0070);
    u_mst.acc(1'b1, 8'h00, 16'h0001, 16'h0009);
    `CHK({u_mst.last.valid, run_eff}, {1'b0, 11'h079})
    u_mst.acc(1'b1, 8'h00, 16'h0002, 16'h7530);
    `CHK({sp_bc, setpt}, {1'b1, 16'h7530})
    u_mst.acc(1'b1, 8'h00, 16'h0003, 16'h0100);
    `CHK(vgain, 16'h07d0)
    u_mst.acc(1'b1, 8'h21, 16'h0002, 16'h0001);
    `CHK({u_mst.last.valid, setpt}, {1'b0, 16'h7530})
    @(posedge clk) own <= 8'h21;
    u_mst.acc(1'b0, 8'h21, 16'h0003, 16'h0000);
    `CHK(u_mst.last.valid, 1'b0)
    @(posedge clk) own <= 8'h20;
    wr(16'h0001, 16'h0000);
  endtask
  // Unit select and single-slave setpoint
  task automatic t_unit;
    wr(16'h0198, 16'h0001);
    `CHK(unit, 16'h0001)
    rd(16'h0198, 16'h0001);
    wr(16'h0002, 16'h1770);
    `CHK({sp_bc, setpt}, {1'b0, 16'h1770})
    rd(16'h0002, 16'h1770);
  endtask
  // Monitors pass through in link units
  task automatic t_mon;
    logic [15:0] r [9] = '{16'h0027, 16'h0028, 16'h0031, 16'h0037, 16'h0038, 16'h0039, 16'h003a,
      16'h0023, 16'h0024};
    logic [15:0] v [9] = '{16'h01f4, 16'h00c8, 16'h0136, 16'hff38, 16'h03e8, 16'hfc18, 16'h0064,
      16'h1770, 16'h1388};
    @(posedge clk) mon <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, v[7], v[8], v[0], v[1], 16'h0,
      16'h0, 16'h0, v[2], 16'h0, 16'h0010, v[3], v[4], v[5], v[6], 16'h0};
    for (int i = 0; i < 9; i++) rd(r[i], v[i]);
    rd(16'h0035, 16'h0000);
    rd(16'h0020, 16'h0007);
  endtask
  // Sticky fault flag and its reset
  task automatic t_fault;
    @(posedge clk) f1 <= 16'h0081;
    @(posedge clk) f1 <= 16'h0000;
    rd(16'h0021, 16'h0081);
    wr(16'h0001, 16'h0008);
    wr(16'h0001, 16'h0000);
    rd(16'h0021, 16'h0000);
    @(posedge clk) f1 <= 16'h0002;
    wr(16'h0001, 16'h0008);
    wr(16'h0001, 16'h0000);
    @(posedge clk) f1 <= 16'h0000;
    rd(16'h0021, 16'h0002);
  endtask
  // Output terminals by function select
  task automatic t_out;
    @(posedge clk) sel <= '{8'h12, 8'h12, 8'h12};
    @(posedge clk) core <= 3'b010;
    wr(16'h0009, 16'h0005);
    `CHK(out_term, 3'b101)
    rd(16'h0009, 16'h0005);
    @(posedge clk) sel <= '{8'h12, 8'h00, 8'h12};
    @(posedge clk) #1;
    `CHK(out_term, 3'b111)
    rd(16'h0020, 16'h00e7);
  endtask
  // Reset in mid-run brings back the reset values
  task automatic t_reset;
    wr(16'h0198, 16'h0002);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1;
    `CHK({vgain, unit, setpt, sp_bc, out_term}, {16'h03e8, 16'h0000, 16'h0000, 1'b0, 3'b010})
    rd(16'h0021, 16'h0000);
    rd(16'h0009, 16'h0000);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Clock
  always #5 clk = ~clk;
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    term = '0;
    f1 = '0;
    mon = '0;
    core = '0;
    sel = '{8'h00, 8'h00, 8'h00};
    own = 8'h20;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_cmd();
    t_gain();
    t_map();
    t_bcast();
    t_unit();
    t_mon();
    t_fault();
    t_out();
    t_reset();
    stop_test();
  end
  // Watchdog
  initial begin
    #50000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
